/* hdl/dtp_top.sv */
// Dual timer PWM unit: two 16-bit timers with PWM and frequency modes; timer A also has a split mode.
// Assumes an 8-bit register port; wave pins are push-pull when PWM is enabled.
`timescale 1ns/1ps
`include "dtp_map.svh"

// Contract
// R1: Per-timer enable bit makes 8-bit PWM
// R2: PWM drives waveform on count-input pin
// R3: Software selects internal counting, pin output
// R4: Overflow flags and baud tick keep working
// R5: Two mode bits pick four sub-modes
// R6: High at 00H, low at compare match
// R7: Overflow copies duty to compare, sets high
// R8: Duty writes wait for FFH to 00H
// R9: Duty 00H holds output low
// R10: Mode 0 logarithmic low-byte prescaler
// R11: Mode 1 linear prescaler with reload
// R12: Mode 2 auto-reload, toggle on overflow
// R13: Mode 2 leaves reload registers unused
// R14: Timer B mode 3 freezes count
// R15: Timer A mode 3 splits bytes
// R16: Split duties from reloads, freq clock/256
// R17: Timer B mode 3 stops it, baud ok
// R18: Prescale bits plus one, reset 100B
// R19: Enable B bit 7, A bit 6
// R20: System prescaler divides clock by value+1
module dtp_top
	import dtp_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       ext_irq_pin_a,
	input  wire logic       wave_pin_a_in,
	input  wire logic       wave_pin_b_in,
	output logic            wave_pin_a_out,
	output logic            wave_pin_a_oe,
	output logic            wave_pin_b_out,
	output logic            wave_pin_b_oe,
	output logic            ovf_flag_a,
	output logic            ovf_flag_b,
	output logic            baud_tick
);
	// ==========================================
	// Registers
	logic [7:0] aux_timer_ctrl_reg_r;
	logic [7:0] timer_mode_reg_r;
	logic [7:0] ctrl_r;
	logic [7:0] lo_byte_a_r, lo_byte_b_r;
	logic [7:0] hi_count_a_r, hi_count_b_r;
	logic [7:0] lo_reload_a_r, lo_reload_b_r;
	logic [7:0] hi_reload_a_r, hi_reload_b_r;
	logic [7:0] sys_prescale_r;
	logic [7:0] presc_cnt_r;
	logic [7:0] rdata_nxt;
	logic       wave_a_r, wave_b_r;
	logic       pin_a_s, pin_b_s, irq_a_s;

	dtp_mode_type mode_a, mode_b;
	logic         mod_enable_a, mod_enable_b;
	logic         run_ctrl_a, run_ctrl_b;
	logic         tick;
	logic [2:0]   log_prescale_sel_a, log_prescale_sel_b;

	assign mod_enable_a       = aux_timer_ctrl_reg_r[`DTP_AUX_EN_A]; // R19
	assign mod_enable_b       = aux_timer_ctrl_reg_r[`DTP_AUX_EN_B]; // R19
	assign log_prescale_sel_a = aux_timer_ctrl_reg_r[2:0];
	assign log_prescale_sel_b = aux_timer_ctrl_reg_r[5:3];
	assign mode_a             = dtp_mode_type'(timer_mode_reg_r[1:0]); // R5
	assign mode_b             = dtp_mode_type'(timer_mode_reg_r[5:4]); // R5
	assign run_ctrl_a         = ctrl_r[`DTP_TCTL_RUN_A];
	assign run_ctrl_b         = ctrl_r[`DTP_TCTL_RUN_B];
	assign ovf_flag_a         = ctrl_r[`DTP_TCTL_OVF_A];
	assign ovf_flag_b         = ctrl_r[`DTP_TCTL_OVF_B];

	// ==========================================
	// Pin synchronisers
	dtp_sync u_sync_irq (.ref_clk(ref_clk), .rstn(rstn), .din(ext_irq_pin_a), .dout(irq_a_s));
	dtp_sync u_sync_pa  (.ref_clk(ref_clk), .rstn(rstn), .din(wave_pin_a_in), .dout(pin_a_s));
	dtp_sync u_sync_pb  (.ref_clk(ref_clk), .rstn(rstn), .din(wave_pin_b_in), .dout(pin_b_s));

	// ==========================================
	// System prescaler
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			presc_cnt_r <= `DTP_ZERO8;
		end else if (presc_cnt_r >= sys_prescale_r) begin
			presc_cnt_r <= `DTP_ZERO8; // R20
		end else begin
			presc_cnt_r <= presc_cnt_r + 8'h01; // R20
		end
	end
	assign tick = (presc_cnt_r >= sys_prescale_r); // R20

	// ==========================================
	// Count enables
	// Gating on the pin is only honoured for timer A; counting input from pins is not modelled in PWM use
	logic gate_a_ok, cnt_a_en, cnt_b_en, split_a;
	assign gate_a_ok = !timer_mode_reg_r[`DTP_TMODE_GATE_A] || irq_a_s; // R15
	assign cnt_a_en  = tick && run_ctrl_a && gate_a_ok;
	assign split_a   = mod_enable_a && (mode_a == DTP_SPLIT);
	// Timer B stops in its own mode 3, as if its run bit were clear
	assign cnt_b_en  = tick && run_ctrl_b && (mode_b != DTP_SPLIT); // R14 R17

	function automatic logic lo_wrap(input logic [7:0] lo, input logic [2:0] sel, input dtp_mode_type md);
		logic [7:0] mask;
		mask = `DTP_FULL8 >> (3'h7 - sel);
		unique case (md)
			DTP_LOG_PWM: lo_wrap = ((lo & mask) == mask); // R10 R18
			default:     lo_wrap = (lo == `DTP_FULL8); // R11 R12
		endcase
	endfunction : lo_wrap

	logic lo_a_ovf, lo_b_ovf, hi_a_ovf, hi_b_ovf, hi_a_tick, hi_b_tick, lo_a_tick;
	logic hi_a_run;
	assign lo_a_tick = cnt_a_en;
	assign lo_a_ovf  = lo_a_tick && lo_wrap(lo_byte_a_r, log_prescale_sel_a, mode_a);
	assign lo_b_ovf  = cnt_b_en && lo_wrap(lo_byte_b_r, log_prescale_sel_b, mode_b);
	// In split mode the high byte of A is a free timer on B's run bit
	assign hi_a_run  = split_a ? (tick && run_ctrl_b) : lo_a_ovf; // R15 R16
	assign hi_a_tick = (mode_a == DTP_FREQ_GEN) ? 1'b0 : hi_a_run;
	assign hi_b_tick = (mode_b == DTP_FREQ_GEN) ? 1'b0 : lo_b_ovf;
	assign hi_a_ovf  = hi_a_tick && (hi_count_a_r == `DTP_FULL8);
	assign hi_b_ovf  = hi_b_tick && (hi_count_b_r == `DTP_FULL8);

	// ==========================================
	// Low bytes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			lo_byte_a_r <= `DTP_ZERO8;
		end else if (reg_wr && reg_addr == `DTP_OFS_LO_A) begin
			lo_byte_a_r <= reg_wdata;
		end else if (lo_a_tick) begin
			if (lo_a_ovf && mode_a == DTP_LIN_PWM) begin
				lo_byte_a_r <= lo_reload_a_r; // R11
			end else if (lo_a_ovf && mode_a == DTP_FREQ_GEN) begin
				lo_byte_a_r <= hi_count_a_r; // R12
			end else if (lo_a_ovf && mode_a == DTP_LOG_PWM) begin
				lo_byte_a_r <= `DTP_ZERO8; // R10
			end else begin
				lo_byte_a_r <= lo_byte_a_r + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			lo_byte_b_r <= `DTP_ZERO8;
		end else if (reg_wr && reg_addr == `DTP_OFS_LO_B) begin
			lo_byte_b_r <= reg_wdata;
		end else if (cnt_b_en) begin
			if (lo_b_ovf && mode_b == DTP_LIN_PWM) begin
				lo_byte_b_r <= lo_reload_b_r; // R11
			end else if (lo_b_ovf && mode_b == DTP_FREQ_GEN) begin
				lo_byte_b_r <= hi_count_b_r; // R12
			end else if (lo_b_ovf) begin
				lo_byte_b_r <= `DTP_ZERO8; // R10
			end else begin
				lo_byte_b_r <= lo_byte_b_r + 8'h01;
			end
		end
	end

	// ==========================================
	// High bytes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hi_count_a_r <= `DTP_ZERO8;
		end else if (reg_wr && reg_addr == `DTP_OFS_HI_A) begin
			hi_count_a_r <= reg_wdata;
		end else if (hi_a_tick) begin
			hi_count_a_r <= hi_count_a_r + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hi_count_b_r <= `DTP_ZERO8;
		end else if (reg_wr && reg_addr == `DTP_OFS_HI_B) begin
			hi_count_b_r <= reg_wdata;
		end else if (hi_b_tick) begin
			hi_count_b_r <= hi_count_b_r + 8'h01;
		end
	end

	// ==========================================
	// Overflow flags; hardware set wins over software clear
	logic ovf_a_evt, ovf_b_evt, baud_evt;
	// Split: low byte of A drives flag A, high byte of A drives flag B
	assign ovf_a_evt = split_a ? (lo_a_tick && lo_byte_a_r == `DTP_FULL8)
	                 : ((mode_a == DTP_FREQ_GEN) ? lo_a_ovf : hi_a_ovf); // R4 R15
	assign ovf_b_evt = split_a ? hi_a_ovf
	                 : ((mode_b == DTP_FREQ_GEN) ? lo_b_ovf : hi_b_ovf); // R4 R15
	assign baud_evt  = (mode_b == DTP_FREQ_GEN) ? lo_b_ovf : hi_b_ovf; // R4 R17

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= `DTP_ZERO8;
		end else begin
			if (reg_wr && reg_addr == `DTP_OFS_TCTL) begin
				ctrl_r <= reg_wdata;
			end
			if (ovf_a_evt) begin
				ctrl_r[`DTP_TCTL_OVF_A] <= 1'b1; // R4
			end
			if (ovf_b_evt) begin
				ctrl_r[`DTP_TCTL_OVF_B] <= 1'b1; // R4
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			baud_tick <= 1'b0;
		end else begin
			baud_tick <= baud_evt; // R4
		end
	end

	// ==========================================
	// Configuration registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			aux_timer_ctrl_reg_r <= `DTP_AUX_RST; // R18
			timer_mode_reg_r     <= `DTP_ZERO8;
			sys_prescale_r       <= `DTP_ZERO8;
		end else if (reg_wr) begin
			if (reg_addr == `DTP_OFS_AUX) aux_timer_ctrl_reg_r <= reg_wdata; // R1
			if (reg_addr == `DTP_OFS_TMODE) timer_mode_reg_r <= reg_wdata;
			if (reg_addr == `DTP_OFS_PRESC) sys_prescale_r <= reg_wdata;
		end
	end

	// Reloads are plain storage; mode 2 never reads them so software may use them freely
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			lo_reload_a_r <= `DTP_ZERO8;
			lo_reload_b_r <= `DTP_ZERO8;
			hi_reload_a_r <= `DTP_ZERO8;
			hi_reload_b_r <= `DTP_ZERO8;
		end else if (reg_wr) begin
			if (reg_addr == `DTP_OFS_RL_A) lo_reload_a_r <= reg_wdata; // R13
			if (reg_addr == `DTP_OFS_RL_B) lo_reload_b_r <= reg_wdata; // R13
			if (reg_addr == `DTP_OFS_RH_A) hi_reload_a_r <= reg_wdata; // R13
			if (reg_addr == `DTP_OFS_RH_B) hi_reload_b_r <= reg_wdata; // R13
		end
	end

	// ==========================================
	// PWM channels
	logic       pwm_a_act, pwm_b_act, pwm_hi_a_act;
	logic       wave_a_pwm, wave_b_pwm;
	logic       lo_a_wrap_pulse;
	logic [7:0] duty_a, duty_hi_a;
	assign pwm_a_act       = mod_enable_a && (mode_a == DTP_LOG_PWM || mode_a == DTP_LIN_PWM || split_a);
	assign pwm_b_act       = mod_enable_b && (mode_b == DTP_LOG_PWM || mode_b == DTP_LIN_PWM) && !split_a;
	assign pwm_hi_a_act    = split_a && mod_enable_b; // R15
	assign lo_a_wrap_pulse = lo_a_tick && lo_byte_a_r == `DTP_FULL8;
	assign duty_a          = split_a ? lo_reload_a_r : hi_reload_a_r; // R16
	assign duty_hi_a       = hi_reload_a_r; // R16

	dtp_chan u_chan_a (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.active  (pwm_a_act),
		.ovf     (split_a ? lo_a_wrap_pulse : hi_a_ovf),
		.tick    (split_a ? lo_a_tick : hi_a_tick),
		.cnt     (split_a ? lo_byte_a_r : hi_count_a_r),
		.duty    (duty_a),
		.wave    (wave_a_pwm)
	);

	dtp_chan u_chan_b (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.active  (pwm_b_act || pwm_hi_a_act),
		.ovf     (split_a ? hi_a_ovf : hi_b_ovf),
		.tick    (split_a ? hi_a_tick : hi_b_tick),
		.cnt     (split_a ? hi_count_a_r : hi_count_b_r),
		.duty    (split_a ? duty_hi_a : hi_reload_b_r),
		.wave    (wave_b_pwm)
	);

	// ==========================================
	// Frequency generator toggles
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wave_a_r <= 1'b0;
			wave_b_r <= 1'b0;
		end else begin
			if (lo_a_ovf && mode_a == DTP_FREQ_GEN) wave_a_r <= !wave_a_r; // R12
			if (lo_b_ovf && mode_b == DTP_FREQ_GEN) wave_b_r <= !wave_b_r; // R12
		end
	end

	// ==========================================
	// Pin drive
	assign wave_pin_a_oe  = mod_enable_a; // R2 R3
	assign wave_pin_b_oe  = mod_enable_b; // R2 R3
	assign wave_pin_a_out = (mode_a == DTP_FREQ_GEN) ? wave_a_r : wave_a_pwm; // R2
	assign wave_pin_b_out = (!split_a && mode_b == DTP_FREQ_GEN) ? wave_b_r : wave_b_pwm; // R2

	// ==========================================
	// Register read port
	always_comb begin
		unique case (reg_addr)
			`DTP_OFS_TCTL:  rdata_nxt = ctrl_r;
			`DTP_OFS_TMODE: rdata_nxt = timer_mode_reg_r;
			`DTP_OFS_LO_A:  rdata_nxt = lo_byte_a_r;
			`DTP_OFS_LO_B:  rdata_nxt = lo_byte_b_r;
			`DTP_OFS_HI_A:  rdata_nxt = hi_count_a_r;
			`DTP_OFS_HI_B:  rdata_nxt = hi_count_b_r;
			`DTP_OFS_AUX:   rdata_nxt = aux_timer_ctrl_reg_r;
			`DTP_OFS_RL_A:  rdata_nxt = lo_reload_a_r;
			`DTP_OFS_RL_B:  rdata_nxt = lo_reload_b_r;
			`DTP_OFS_RH_A:  rdata_nxt = hi_reload_a_r;
			`DTP_OFS_RH_B:  rdata_nxt = hi_reload_b_r;
			`DTP_OFS_PRESC: rdata_nxt = sys_prescale_r;
			default:        rdata_nxt = {6'h00, pin_b_s, pin_a_s};
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= `DTP_ZERO8;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= `DTP_ZERO8;
		end
	end
endmodule : dtp_top

/* pkg/dtp_map.svh */
// Register offsets, field positions, reset values and timing constants for the dual timer PWM unit.
// Assumes an 8-bit register port with one-cycle read latency.
`ifndef DTP_MAP_SVH
`define DTP_MAP_SVH

// ==========================================
// Register offsets
`define DTP_OFS_TCTL     4'h0
`define DTP_OFS_TMODE    4'h1
`define DTP_OFS_LO_A     4'h2
`define DTP_OFS_LO_B     4'h3
`define DTP_OFS_HI_A     4'h4
`define DTP_OFS_HI_B     4'h5
`define DTP_OFS_AUX      4'h6
`define DTP_OFS_RL_A     4'h7
`define DTP_OFS_RL_B     4'h8
`define DTP_OFS_RH_A     4'h9
`define DTP_OFS_RH_B     4'ha
`define DTP_OFS_PRESC    4'hb

// ==========================================
// Field positions
`define DTP_AUX_EN_B     7
`define DTP_AUX_EN_A     6
`define DTP_TCTL_RUN_A   0
`define DTP_TCTL_RUN_B   1
`define DTP_TCTL_OVF_A   2
`define DTP_TCTL_OVF_B   3
`define DTP_TMODE_GATE_A 3
`define DTP_TMODE_CT_A   2
`define DTP_TMODE_CT_B   6

// ==========================================
// Reset values
`define DTP_AUX_RST      8'h24
`define DTP_ZERO8        8'h00
`define DTP_FULL8        8'hff

// ==========================================
// Timing
`define DTP_CLK_NS       100

`endif

/* pkg/dtp_pkg.sv */
// Types for the dual timer PWM unit.
// Assumes the map header supplies all numeric constants.
package dtp_pkg;
	typedef enum logic [1:0] {
		DTP_LOG_PWM,
		DTP_LIN_PWM,
		DTP_FREQ_GEN,
		DTP_SPLIT
	} dtp_mode_type;
endpackage : dtp_pkg

/* hdl/dtp_sync.sv */
// Two-flop synchroniser for pin inputs.
// Assumes a single clock domain on ref_clk.
`timescale 1ns/1ps
module dtp_sync (
	input  wire logic ref_clk,
	input  wire logic rstn,
	input  wire logic din,
	output logic      dout
);
	logic meta_r;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= 1'b0;
			dout   <= 1'b0;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule : dtp_sync

/* hdl/dtp_chan.sv */
// One 8-bit PWM compare channel: compare shadow and waveform output.
// Assumes ovf pulses on the FFH to 00H wrap and cnt is the running count.
`timescale 1ns/1ps
`include "dtp_map.svh"
module dtp_chan (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       active,
	input  wire logic       ovf,
	input  wire logic       tick,
	input  wire logic [7:0] cnt,
	input  wire logic [7:0] duty,
	output logic            wave
);
	logic [7:0] compare_shadow_r;

	// Duty reaches the compare only on wrap, so mid-period writes never glitch
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			compare_shadow_r <= `DTP_ZERO8;
		end else if (active && ovf) begin
			compare_shadow_r <= duty; // R7 R8
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wave <= 1'b0;
		end else if (!active) begin
			wave <= 1'b0;
		end else if (ovf) begin
			wave <= (duty != `DTP_ZERO8); // R6 R7 R9
		end else if (tick && (cnt + 8'h01 == compare_shadow_r)) begin
			wave <= 1'b0; // R6
		end else if (compare_shadow_r == `DTP_ZERO8) begin
			wave <= 1'b0; // R9
		end
	end
endmodule : dtp_chan

/* bench/dtp_top_checker.sv */
// Assertion checker for the dual timer PWM unit.
// Assumes it is bound to dtp_top and sees its ports only.
`timescale 1ns/1ps
module dtp_top_checker (
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       wave_pin_a_out,
	input wire logic       wave_pin_a_oe,
	input wire logic       wave_pin_b_oe,
	input wire logic       ovf_flag_a,
	input wire logic       ovf_flag_b,
	input wire logic       baud_tick
);
	// ==========================================
	// Shadows of the writable registers
	logic [7:0] sh_r [0:11];
	logic [7:0] rd_exp_r;
	logic       rd_chk_r;
	logic [9:0] quiet_r;
	wire        ctrl_wr = reg_wr && reg_addr == 4'h0;
	wire  [1:0] mode_a  = sh_r[1][1:0];
	wire  [1:0] mode_b  = sh_r[1][5:4];
	// Duty zero, mode 0, shortest prescale: a period fits well inside 600 quiet cycles
	wire        zero_cfg = sh_r[6][6] && sh_r[1][3:0] == 4'h0 && sh_r[0][0] && sh_r[6][2:0] == 3'h0
		&& sh_r[9] == 8'h00 && sh_r[11] == 8'h00;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 12; i++)
				sh_r[i] <= (i == 6) ? 8'h24 : 8'h00;
		end else if (reg_wr && reg_addr <= 4'hb) begin
			sh_r[reg_addr] <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_chk_r <= 1'b0;
			rd_exp_r <= 8'h00;
		end else begin
			rd_chk_r <= reg_rd && (reg_addr == 4'h1 || (reg_addr >= 4'h6 && reg_addr <= 4'hb));
			rd_exp_r <= sh_r[reg_addr];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			quiet_r <= 10'h000;
		else if (reg_wr)
			quiet_r <= 10'h000;
		else if (quiet_r != 10'h3ff)
			quiet_r <= quiet_r + 10'h001;
	end

	// ==========================================
	// Properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	oe_a_bit_a: assert property (wave_pin_a_oe == sh_r[6][6])
		else $error("pin a drive differs from its enable bit");
	oe_b_bit_a: assert property (wave_pin_b_oe == sh_r[6][7])
		else $error("pin b drive differs from its enable bit");
	oe_hold_a: assert property (!(reg_wr && reg_addr == 4'h6) |=> $stable(wave_pin_a_oe) && $stable(wave_pin_b_oe))
		else $error("pin drive changed without a control write");
	reg_read_a: assert property (rd_chk_r |-> reg_rdata == rd_exp_r)
		else $error("register read back differs from last write");
	freeze_b_a: assert property ((mode_b == 2'b11 && mode_a != 2'b11 && !ctrl_wr) [*3] |-> !$rose(ovf_flag_b))
		else $error("frozen timer b still overflowed");
	run_off_a: assert property ((!sh_r[0][0] && !ctrl_wr) [*3] |-> !$rose(ovf_flag_a))
		else $error("stopped timer a still overflowed");
	baud_flag_a: assert property (baud_tick && mode_a != 2'b11 && !ctrl_wr |-> ##[0:1] ovf_flag_b)
		else $error("baud tick without timer b overflow flag");
	duty_zero_a: assert property (zero_cfg && quiet_r >= 10'h258 |-> !wave_pin_a_out)
		else $error("zero duty output went high");
endmodule : dtp_top_checker

/* bench/dual_timer_pwm_unit_bench.sv */
// Self-checking bench for the dual timer PWM unit.
// Assumes a 10 MHz clock and the offsets of the design's map header.
`timescale 1ns/1ps
module dual_timer_pwm_unit_bench;
	logic        ref_clk, rstn, reg_wr, reg_rd, ext_irq;
	logic  [3:0] reg_addr;
	logic  [7:0] reg_wdata, reg_rdata, d;
	logic        pa, pa_oe, pb, pb_oe, ovf_a, ovf_b, baud;
	logic [15:0] hi, per;
	int          n_fail, check_count, n;
	logic  [7:0] mtab [0:3] = '{8'h22, 8'h32, 8'h23, 8'h33};

	dtp_top dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin_a(ext_irq), .wave_pin_a_in(pa_oe ? pa : 1'b1),
		.wave_pin_b_in(pb_oe ? pb : 1'b1), .wave_pin_a_out(pa), .wave_pin_a_oe(pa_oe), .wave_pin_b_out(pb),
		.wave_pin_b_oe(pb_oe), .ovf_flag_a(ovf_a), .ovf_flag_b(ovf_b), .baud_tick(baud));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// ==========================================
	// Bus, compare and waveform tasks
	task automatic check(input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		v = reg_rdata;
	endtask : rd

	// Bounded so a dead pin cannot hang the run
	task automatic wait_lvl(input logic b, v, inout logic [15:0] c);
		int k;
		k = 0;
		while ((b ? pb : pa) !== v && k < 3000) begin
			@(negedge ref_clk);
			k++;
			c++;
		end
		if (k == 3000) begin
			n_fail++;
			$display("wrong value at %0t: pin level never reached", $time);
		end
	endtask : wait_lvl

	task automatic meas(input logic b, output logic [15:0] h, p);
		logic [15:0] junk;
		junk = 16'h0;
		h = 16'h0;
		p = 16'h0;
		@(negedge ref_clk);
		wait_lvl(b, 1'b0, junk);
		wait_lvl(b, 1'b1, junk);
		wait_lvl(b, 1'b0, h);
		wait_lvl(b, 1'b1, p);
		p = p + h;
	endtask : meas

	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	initial begin
		#5000000;
		n_fail++;
		give_verdict();
	end

	// ==========================================
	// Scenarios
	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		ext_irq = 1'b1;
		n_fail = 0;
		check_count = 0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(4'h6, d);
		check({8'h00, d}, 16'h0024);
		check({14'h0, ovf_b, ovf_a}, 16'h0000);
		wr(4'h6, 8'h80);
		@(negedge ref_clk);
		check({14'h0, pb_oe, pa_oe}, 16'h0002);
		// Frequency generator; reload registers are free storage here
		// Count source bits stay clear: counting is internal while the pin drives
		wr(4'h1, 8'h02);
		wr(4'h4, 8'hf0);
		wr(4'h7, 8'ha5);
		wr(4'h9, 8'h5a);
		wr(4'h6, 8'h40);
		wr(4'h0, 8'h01);
		meas(1'b0, hi, per);
		check(per, 16'h0020);
		check({15'h0, ovf_a}, 16'h0001);
		rd(4'h7, d);
		check({8'h00, d}, 16'h00a5);
		wr(4'hb, 8'h01);
		meas(1'b0, hi, per);
		check(per, 16'h0040);
		wr(4'hb, 8'h00);
		// Linear prescale, then a duty change in mid-pulse
		wr(4'h1, 8'h01);
		wr(4'h7, 8'hff);
		wr(4'h9, 8'h40);
		meas(1'b0, hi, per);
		check(hi, 16'h0040);
		check(per, 16'h0100);
		fork
			meas(1'b0, hi, per);
			begin
				@(posedge pa);
				repeat (8) @(posedge ref_clk);
				wr(4'h9, 8'h10);
			end
		join
		check(hi, 16'h0040);
		meas(1'b0, hi, per);
		check(hi, 16'h0010);
		// Logarithmic prescale with one active bit, then zero duty
		wr(4'h1, 8'h00);
		wr(4'h9, 8'h40);
		meas(1'b0, hi, per);
		check(per, 16'h0200);
		check(hi, 16'h0080);
		wr(4'h9, 8'h00);
		repeat (700) @(negedge ref_clk);
		n = 0;
		repeat (600) begin
			@(negedge ref_clk);
			if (pa !== 1'b0)
				n++;
		end
		check(16'(n), 16'h0);
		// Split timer a: low byte on pin a, high byte on pin b
		wr(4'h1, 8'h03);
		wr(4'h7, 8'h20);
		wr(4'h9, 8'h60);
		wr(4'h6, 8'hc0);
		wr(4'h0, 8'h03);
		meas(1'b0, hi, per);
		check(hi, 16'h0020);
		check(per, 16'h0100);
		meas(1'b1, hi, per);
		check(hi, 16'h0060);
		check({14'h0, ovf_b, ovf_a}, 16'h0003);
		// Gated low byte halts while the gate pin is low
		wr(4'h1, 8'h0b);
		@(posedge ref_clk);
		ext_irq <= 1'b0;
		repeat (4) @(negedge ref_clk);
		d[0] = pa;
		n = 0;
		repeat (600) begin
			@(negedge ref_clk);
			if (pa !== d[0])
				n++;
		end
		check(16'(n), 16'h0);
		@(posedge ref_clk);
		ext_irq <= 1'b1;
		// Timer b runs or halts by its own mode, split or not
		wr(4'h5, 8'hf0);
		for (int i = 0; i < 4; i++) begin
			wr(4'h1, mtab[i]);
			wr(4'h0, 8'h03);
			n = 0;
			repeat (300) begin
				@(negedge ref_clk);
				if (baud === 1'b1)
					n++;
			end
			check({15'h0, n != 0}, {15'h0, i % 2 == 0});
		end
		give_verdict();
	end
endmodule : dual_timer_pwm_unit_bench

bind dtp_top dtp_top_checker chk (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.wave_pin_a_out, .wave_pin_a_oe, .wave_pin_b_oe, .ovf_flag_a, .ovf_flag_b, .baud_tick);
